/* core/slss_pkg.sv */
// Package for the serial link setting select block.
// Assumes a 125 MHz pclk; all other files except the wiring model import it whole.
package slss_pkg;

  localparam int unsigned SLSS_CLK_HZ = 125_000_000;
  localparam int unsigned SLSS_ADDR_W = 6;
  localparam int unsigned SLSS_CODE_W = 2;
  localparam int unsigned SLSS_SW_W = 8;
  localparam int unsigned SLSS_DIV_W = 16;

  // Field positions inside the switch bank
  localparam int unsigned SLSS_ADDR_LSB = 0;
  localparam int unsigned SLSS_CODE_LSB = 6;

  // Bit-rate codes; zero means "use stored value"
  localparam logic [1:0] SLSS_CODE_NVM = 2'h0;
  localparam logic [1:0] SLSS_CODE_9K6 = 2'h1;
  localparam logic [1:0] SLSS_CODE_38K4 = 2'h2;
  localparam logic [1:0] SLSS_CODE_115K2 = 2'h3;

  // Rates in bits per second, as printed in kbps times 1000
  localparam int unsigned SLSS_RATE_9K6 = 9_600;
  localparam int unsigned SLSS_RATE_38K4 = 38_400;
  localparam int unsigned SLSS_RATE_115K2 = 115_200;

  // Clocks per bit, rounded down, never below one
  localparam logic [15:0] SLSS_DIV_9K6 = 16'(SLSS_CLK_HZ / SLSS_RATE_9K6);
  localparam logic [15:0] SLSS_DIV_38K4 = 16'(SLSS_CLK_HZ / SLSS_RATE_38K4);
  localparam logic [15:0] SLSS_DIV_115K2 = 16'(SLSS_CLK_HZ / SLSS_RATE_115K2);

  // Reset values
  localparam logic [5:0] SLSS_ADDR_RST = 6'h00;
  localparam logic [1:0] SLSS_CODE_RST = 2'h0;
  localparam logic [15:0] SLSS_DIV_RST = 16'h0000;
  // Synchroniser start: select at its pull-up level (RS-232), switches open
  localparam logic [8:0] SLSS_PINS_RST = 9'h100;
  // Last count of the settle wait while the synchroniser fills
  localparam logic [1:0] SLSS_SETTLE_LAST = 2'h3;

  // APB register map (byte addresses)
  localparam logic [7:0] SLSS_REG_CTRL = 8'h00;
  localparam logic [7:0] SLSS_REG_STATUS = 8'h04;
  localparam logic [7:0] SLSS_REG_NVM = 8'h08;
  localparam logic [7:0] SLSS_REG_RESULT = 8'h0C;
  localparam logic [7:0] SLSS_REG_DIV = 8'h10;

  // Control register fields
  localparam int unsigned SLSS_CTRL_RESAMPLE = 0;

  localparam logic [7:0] SLSS_NVM_RST = 8'h00;

  typedef enum logic [1:0] {SLSS_SYNC, SLSS_LOAD, SLSS_DONE} slss_state_t;

endpackage

/* core/slss_sync.sv */
// Two-flop synchroniser bank for pin inputs.
// Assumes inputs asynchronous to pclk; first stage read only by second.
`timescale 1ns/1ps
`default_nettype none
module slss_sync
  import slss_pkg::*;
#(
  parameter int unsigned WIDTH = 9,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // Start at the pins' idle levels so no false change follows reset
      stage1 <= RST_VAL;
      dout <= RST_VAL;
    end
    else
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end

endmodule // slss_sync
`default_nettype wire

/* core/slss_top.sv */
// Serial link setting select: resolves node address and bit rate from switches.
// Assumes switch pins are active high when closed and stable at reset release.
`timescale 1ns/1ps
`default_nettype none
module slss_top
  import slss_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] sw_closed,
  input wire logic port_select,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic rs485_mode,
  output logic [5:0] node_addr,
  output logic [15:0] bit_div,
  output logic settings_valid
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [8:0] pins_sync;

  slss_sync #(.WIDTH(9), .RST_VAL(SLSS_PINS_RST)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({port_select, sw_closed}),
    .dout(pins_sync)
  );

  logic [7:0] sw_s;
  logic sel_s;
  assign sw_s = pins_sync[7:0];
  assign sel_s = pins_sync[8];

  ////////////////////////////////////////////////////////////////////////
  // Sampling and resolution

  slss_state_t state, next_state;
  logic [5:0] sw_addr, next_sw_addr;
  logic [1:0] sw_code, next_sw_code;
  logic [5:0] next_node_addr;
  logic [1:0] rate_code;
  logic [15:0] next_bit_div;
  logic next_rs485_mode;
  logic next_settings_valid;
  logic [7:0] nvm, next_nvm;
  logic [1:0] settle;
  logic [1:0] next_settle;
  logic resample_req;

  function automatic logic [15:0] slss_code_div(input logic [1:0] code);
    unique case (code)
      SLSS_CODE_9K6: slss_code_div = SLSS_DIV_9K6;
      SLSS_CODE_38K4: slss_code_div = SLSS_DIV_38K4;
      SLSS_CODE_115K2: slss_code_div = SLSS_DIV_115K2;
      SLSS_CODE_NVM: slss_code_div = SLSS_DIV_RST;
    endcase
  endfunction

  // Non-volatile fallback: address low six bits, rate code in bits seven:six
  always_comb
  begin
    next_node_addr = (sw_addr != SLSS_ADDR_RST) ? sw_addr : nvm[5:0];
    rate_code = (sw_code != SLSS_CODE_NVM) ? sw_code : nvm[7:6];
  end

  always_comb
  begin
    next_state = state;
    next_sw_addr = sw_addr;
    next_sw_code = sw_code;
    next_settle = settle;
    next_settings_valid = settings_valid;
    // Mode tracks the pin live; it never alters address or rate
    next_rs485_mode = ~sel_s;
    next_bit_div = bit_div;
    unique case (state)
      SLSS_SYNC:
      begin
        // Wait for the synchroniser to fill before trusting pins
        next_settle = settle + 2'h1;
        if (settle == SLSS_SETTLE_LAST)
          next_state = SLSS_LOAD;
      end
      SLSS_LOAD:
      begin
        next_sw_addr = sw_s[SLSS_ADDR_LSB +: SLSS_ADDR_W];
        next_sw_code = sw_s[SLSS_CODE_LSB +: SLSS_CODE_W];
        next_state = SLSS_DONE;
      end
      SLSS_DONE:
      begin
        next_settings_valid = 1'b1;
        next_bit_div = slss_code_div(rate_code);
        if (resample_req)
        begin
          next_settings_valid = 1'b0;
          next_state = SLSS_LOAD;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= SLSS_SYNC;
      sw_addr <= SLSS_ADDR_RST;
      sw_code <= SLSS_CODE_RST;
      settle <= 2'h0;
      settings_valid <= 1'b0;
      rs485_mode <= 1'b0;
      node_addr <= SLSS_ADDR_RST;
      bit_div <= SLSS_DIV_RST;
    end
    else
    begin
      state <= next_state;
      sw_addr <= next_sw_addr;
      sw_code <= next_sw_code;
      settle <= next_settle;
      settings_valid <= next_settings_valid;
      rs485_mode <= next_rs485_mode;
      node_addr <= (state == SLSS_DONE) ? next_node_addr : node_addr;
      bit_div <= next_bit_div;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states

  logic [31:0] next_prdata;
  logic next_pslverr;
  logic acc;
  logic mapped;

  always_comb
  begin
    acc = psel & ~penable;
    mapped = (paddr == SLSS_REG_CTRL) || (paddr == SLSS_REG_STATUS) || (paddr == SLSS_REG_NVM)
      || (paddr == SLSS_REG_RESULT) || (paddr == SLSS_REG_DIV);
    next_nvm = nvm;
    resample_req = 1'b0;
    if (psel && penable && pwrite && paddr == SLSS_REG_NVM)
      next_nvm = pwdata[7:0];
    if (psel && penable && pwrite && paddr == SLSS_REG_CTRL)
      resample_req = pwdata[SLSS_CTRL_RESAMPLE];
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (acc)
    begin
      next_pslverr = ~mapped;
      unique case (paddr)
        SLSS_REG_STATUS: next_prdata = {28'h0000000, rs485_mode, settings_valid, state == SLSS_DONE, 1'b0};
        SLSS_REG_NVM: next_prdata = {24'h000000, nvm};
        SLSS_REG_RESULT: next_prdata = {16'h0000, sw_code, sw_addr, rate_code, node_addr};
        SLSS_REG_DIV: next_prdata = {16'h0000, bit_div};
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nvm <= SLSS_NVM_RST;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end
    else
    begin
      nvm <= next_nvm;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      pready <= acc;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  AST_ADDR_FROM_SW: assert property (@(posedge pclk) disable iff (!presetn)
    state == SLSS_LOAD |=> sw_addr == $past(sw_s[5:0]))
    else $error("address field not taken from switches one to six");
  AST_CODE_FROM_SW: assert property (@(posedge pclk) disable iff (!presetn)
    state == SLSS_LOAD |=> sw_code == $past(sw_s[7:6]))
    else $error("rate code not taken from switches seven and eight");
  AST_MODE_NO_EFFECT: assert property (@(posedge pclk) disable iff (!presetn)
    state == SLSS_DONE && $past(state) == SLSS_DONE && $changed(rs485_mode) |-> $stable(node_addr))
    else $error("port type change altered node address");
  AST_NVM_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
    state == SLSS_DONE && sw_addr == 6'h00 |=> node_addr == $past(nvm[5:0]))
    else $error("zero address did not select stored address");
  AST_NVM_RATE: assert property (@(posedge pclk) disable iff (!presetn)
    state == SLSS_DONE && sw_code == 2'h0 && nvm[7:6] == 2'h1 |=> bit_div == SLSS_DIV_9K6)
    else $error("zero code did not select stored rate");
  AST_RATE_MAP: assert property (@(posedge pclk) disable iff (!presetn)
    state == SLSS_DONE && sw_code == 2'h3 |=> bit_div == 16'h043D)
    else $error("code three not mapped to 115.2 kbps");
  AST_MODE_PIN: assert property (@(posedge pclk) disable iff (!presetn)
    rs485_mode == ~$past(sel_s))
    else $error("port mode does not follow selection pin");
  AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    state == SLSS_DONE && !resample_req |=> $stable(sw_addr) && $stable(sw_code))
    else $error("switch values changed after sampling");
  AST_VALID_TIME: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> ##[1:10] settings_valid)
    else $error("settings not valid in time");

  COV_SW_ADDR: cover property (@(posedge pclk) disable iff (!presetn) state == SLSS_DONE && sw_addr != 6'h00);
  COV_NVM_ADDR: cover property (@(posedge pclk) disable iff (!presetn) state == SLSS_DONE && sw_addr == 6'h00);
  COV_RATE3: cover property (@(posedge pclk) disable iff (!presetn) settings_valid && bit_div == SLSS_DIV_115K2);
  COV_RESAMPLE: cover property (@(posedge pclk) disable iff (!presetn) resample_req);

endmodule // slss_top
`default_nettype wire

/* testbench/slss_top_tb.sv */
// Self-checking bench for the setting select block.
// Assumes the wiring model drives the pins and the bench is APB master.
`timescale 1ns/1ps
`default_nettype none
module slss_top_tb;
  import slss_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, tie_gnd, port_select;
  logic [7:0] sw_on, sw_closed, paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, rs485_mode, settings_valid, err;
  logic [5:0] node_addr;
  logic [15:0] bit_div;
  int num_errors = 0;
  int n_tests = 0;
  //////////////////////////////////////////////////////////////////////////////
  slss_wiring wiring (.sw_on(sw_on), .tie_gnd(tie_gnd), .sw_closed(sw_closed), .port_select(port_select));
  slss_top dut (.pclk(pclk), .presetn(presetn), .sw_closed(sw_closed), .port_select(port_select),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rs485_mode(rs485_mode), .node_addr(node_addr),
    .bit_div(bit_div), .settings_valid(settings_valid));
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] exp_div(input logic [1:0] c);
    case (c)
      2'h1: exp_div = 16'(SLSS_CLK_HZ / SLSS_RATE_9K6);
      2'h2: exp_div = 16'(SLSS_CLK_HZ / SLSS_RATE_38K4);
      2'h3: exp_div = 16'(SLSS_CLK_HZ / SLSS_RATE_115K2);
      default: exp_div = 16'h0000;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic do_reset(input logic [7:0] sw);
    int n;
    sw_on <= sw;
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    // Pins not yet through the synchroniser: nothing resolved, port idles as RS-232
    chk("valid at release", 32'h0, 32'(settings_valid));
    if (!tie_gnd)
      chk("mode at release", 32'h0, 32'(rs485_mode));
    n = 0;
    while (settings_valid !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50)
    begin
      num_errors++;
      test_done();
    end
    @(posedge pclk);
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      num_errors++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_switch;
    logic [5:0] a;
    for (int i = 1; i < 4; i++)
    begin
      a = (i == 1) ? 6'h01 : (i == 2) ? 6'h20 : 6'h3F;
      do_reset({2'(i), a});
      chk("node_addr", 32'(a), 32'(node_addr));
      chk("bit_div", 32'(exp_div(2'(i))), 32'(bit_div));
    end
    sw_on <= 8'h40;
    repeat (10) @(posedge pclk);
    chk("held addr", 32'h3F, 32'(node_addr));
    chk("held div", 32'(exp_div(2'h3)), 32'(bit_div));
  endtask
  task automatic t_nvm;
    do_reset(8'h00);
    apb(1'b1, SLSS_REG_NVM, 32'h000000EA);
    repeat (3) @(posedge pclk);
    chk("nvm addr", 32'h2A, 32'(node_addr));
    chk("nvm div", 32'(exp_div(2'h3)), 32'(bit_div));
    do_reset(8'h05);
    apb(1'b1, SLSS_REG_NVM, 32'h00000040);
    repeat (3) @(posedge pclk);
    chk("mixed addr", 32'h05, 32'(node_addr));
    chk("mixed div", 32'(exp_div(2'h1)), 32'(bit_div));
  endtask
  task automatic t_mode;
    tie_gnd <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("rs485_mode", 32'h1, 32'(rs485_mode));
    tie_gnd <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("rs232 mode", 32'h0, 32'(rs485_mode));
    chk("rs232 addr", 32'h05, 32'(node_addr));
  endtask
  task automatic t_apb;
    apb(1'b0, 8'h40, 32'h00000000);
    chk("unmapped err", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, SLSS_REG_DIV, 32'h00001234);
    apb(1'b0, SLSS_REG_DIV, 32'h00000000);
    chk("div reg", 32'(exp_div(2'h1)), rd);
  endtask
  // Switches move after sampling; only a resample request picks them up
  task automatic t_resample;
    sw_on <= 8'hC7;
    repeat (6) @(posedge pclk);
    chk("unsampled addr", 32'h05, 32'(node_addr));
    apb(1'b1, SLSS_REG_CTRL, 32'h00000001);
    repeat (3) @(posedge pclk);
    chk("resampled addr", 32'h07, 32'(node_addr));
    chk("resampled div", 32'(exp_div(2'h3)), 32'(bit_div));
    apb(1'b0, SLSS_REG_STATUS, 32'h00000000);
    chk("status", 32'h00000006, rd);
    apb(1'b0, SLSS_REG_RESULT, 32'h00000000);
    chk("result", 32'h0000C7C7, rd);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    sw_on = 8'h00;
    tie_gnd = 1'b0;
    t_switch();
    t_nvm();
    t_mode();
    t_apb();
    t_resample();
    test_done();
  end
endmodule // slss_top_tb
`default_nettype wire

/* testbench/slss_wiring.sv */
// Model of the wiring outside the block: switch bank and select tie.
// Assumes the bench sets switch positions and whether select is grounded.
`timescale 1ns/1ps
`default_nettype none
module slss_wiring
(
  input wire logic [7:0] sw_on,
  input wire logic tie_gnd,
  output logic [7:0] sw_closed,
  output logic port_select
);
  assign sw_closed = sw_on;
  // Open select rests at its pull-up level
  assign port_select = tie_gnd ? 1'b0 : 1'b1;
endmodule // slss_wiring
`default_nettype wire
